// ---- lma_pkg.sv ----
// shared constants and types of the look-up-table memory arbiter
package lma_pkg;
   localparam int        ADDR_W        = 15;
   localparam int        DATA_W        = 8;
   localparam int        N_CONS        = 3;
   localparam int        CONS_RD_A     = 0;
   localparam int        CONS_RD_B     = 1;
   localparam int        CONS_WR       = 2;
   localparam int        READ_CYCLES   = 4;
   localparam int        CLK_PERIOD_NS = 4;
   localparam int        WE_MIN_NS     = 5;
   // least time, so round up
   localparam int        WE_CYCLES     = (WE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int        CNT_W         = 3;
   localparam logic      CTL_OFF       = 1'h1;
   localparam logic      CTL_ON        = 1'h0;

   typedef enum logic [5:0] {
      ST_IDLE     = 6'h01,
      ST_RD       = 6'h02,
      ST_WR_SET   = 6'h04,
      ST_WR_PULSE = 6'h08,
      ST_WR_HOLD  = 6'h10,
      ST_DONE     = 6'h20
   } lma_state_t;
endpackage : lma_pkg

// ---- lma_arb_if.sv ----
// request and grant carrier between the sequencer and its arbiter
`timescale 1ns/100ps
interface lma_arb_if #(parameter int N = 3);
   logic [N-1:0] req;
   logic [N-1:0] gnt;
   logic         any;
   modport arb  (input req, output gnt, output any);
   modport user (output req, input gnt, input any);
endinterface : lma_arb_if

// ---- lma_arb.sv ----
// fixed-order request selector
`timescale 1ns/100ps
module lma_arb #(parameter int N = 3) (
   lma_arb_if.arb ab
);
   // lower index is checked first and always wins
   assign ab.gnt[0] = ab.req[0];
   genvar i;
   generate
      for (i = 1; i < N; i++) begin : g_pri
         assign ab.gnt[i] = ab.req[i] & ~(|ab.req[i-1:0]);
      end
   endgenerate
   assign ab.any = |ab.req;
endmodule : lma_arb

// ---- lma_top.sv ----
// arbiter and sequencer for the external asynchronous sram holding cipher tables
//
// Contract
// - Chip, output and write enables come straight from registers, never from gates.
// - Address and write data are registered and held while the chip is enabled.
// - Idle state waits until at least one of three consumers requests.
// - Completion pulse goes only to the consumer that was served.
// - Other requests stay pending until the current access completes.
// - One fixed-order check picks among simultaneous requests; first checked wins.
// - Read takes four cycles from acceptance to completion with valid data.
// - Write enable asserts after address and data settle, held at least 5 ns.
// - Serves two read-only consumers and one write-only consumer.
// - Reader gives request plus address; data valid on its bus at completion.
// - Writer gives request, address and data; completion marks the write finished.
`timescale 1ns/100ps
module lma_top
   import lma_pkg::*;
#(
   parameter int AW    = ADDR_W,
   parameter int DW    = DATA_W,
   parameter int RD_CY = READ_CYCLES,
   parameter int WE_CY = WE_CYCLES
) (
   input  wire logic          MCLK,
   input  wire logic          RST_B,
   input  wire logic          RD_START_A,
   input  wire logic [AW-1:0] RD_ADDR_A,
   output      logic [DW-1:0] RD_DATA_A,
   output      logic          RD_DONE_A,
   input  wire logic          RD_START_B,
   input  wire logic [AW-1:0] RD_ADDR_B,
   output      logic [DW-1:0] RD_DATA_B,
   output      logic          RD_DONE_B,
   input  wire logic          WR_START,
   input  wire logic [AW-1:0] WR_ADDR,
   input  wire logic [DW-1:0] WR_DATA,
   output      logic          WR_DONE,
   output      logic          RAM_CE_B,
   output      logic          RAM_OE_B,
   output      logic          RAM_WE_B,
   output      logic [AW-1:0] RAM_ADDR,
   input  wire logic [DW-1:0] RAM_DQ_I,
   output      logic [DW-1:0] RAM_DQ_O,
   output      logic          RAM_DQ_OE_B
);

   ////////////////////////////////////////////////////////////////////////////////
   // parameter checks
   generate
      if (RD_CY < 3 || RD_CY > (1 << CNT_W)) begin : g_bad_rd
         $error("read cycle count out of range");
      end
      if (WE_CY < 1 || WE_CY > (1 << CNT_W)) begin : g_bad_we
         $error("write pulse count out of range");
      end
   endgenerate

   localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CY - 2);
   localparam logic [CNT_W-1:0] WE_LOAD = CNT_W'(WE_CY - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // arbitration
   lma_arb_if #(.N(N_CONS)) ab ();

   assign ab.req[CONS_RD_A] = RD_START_A;
   assign ab.req[CONS_RD_B] = RD_START_B;
   assign ab.req[CONS_WR]   = WR_START;

   lma_arb #(.N(N_CONS)) u_arb (
      .ab (ab)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer state
   lma_state_t        state_ff,  nxt_state;
   logic [CNT_W-1:0]  cnt_ff,    nxt_cnt;
   logic [N_CONS-1:0] sel_ff,    nxt_sel;
   logic [N_CONS-1:0] done_ff,   nxt_done;
   logic              ce_b_ff,   nxt_ce_b;
   logic              oe_b_ff,   nxt_oe_b;
   logic              we_b_ff,   nxt_we_b;
   logic              dqoe_b_ff, nxt_dqoe_b;
   logic [AW-1:0]     addr_ff,   nxt_addr;
   logic [DW-1:0]     dq_o_ff,   nxt_dq_o;
   logic [DW-1:0]     rda_ff,    nxt_rda;
   logic [DW-1:0]     rdb_ff,    nxt_rdb;
   logic [DW-1:0]     dq_s1_ff;
   logic [DW-1:0]     dq_s2_ff;

   always_comb begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_sel    = sel_ff;
      nxt_done   = '0;
      nxt_addr   = addr_ff;
      nxt_dq_o   = dq_o_ff;
      nxt_rda    = rda_ff;
      nxt_rdb    = rdb_ff;
      case (state_ff)
         ST_IDLE: begin
            if (ab.any) begin
               nxt_sel = ab.gnt;
               if (ab.gnt[CONS_WR]) begin
                  nxt_addr  = WR_ADDR;
                  nxt_dq_o  = WR_DATA;
                  nxt_state = ST_WR_SET;
               end else begin
                  nxt_addr  = ab.gnt[CONS_RD_A] ? RD_ADDR_A : RD_ADDR_B;
                  nxt_cnt   = RD_LOAD;
                  nxt_state = ST_RD;
               end
            end
         end
         ST_RD: begin
            if (cnt_ff == '0) begin
               // completion and data land on the same edge
               nxt_done  = sel_ff;
               nxt_rda   = sel_ff[CONS_RD_A] ? dq_s2_ff : rda_ff;
               nxt_rdb   = sel_ff[CONS_RD_B] ? dq_s2_ff : rdb_ff;
               nxt_state = ST_DONE;
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
         ST_WR_SET: begin
            // one cycle of settle before the write strobe
            nxt_cnt   = WE_LOAD;
            nxt_state = ST_WR_PULSE;
         end
         ST_WR_PULSE: begin
            if (cnt_ff == '0) begin
               nxt_state = ST_WR_HOLD;
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
         ST_WR_HOLD: begin
            // address and data held one cycle past the strobe's rise
            nxt_done  = sel_ff;
            nxt_state = ST_DONE;
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // strobes decoded from the next state so they leave a flip-flop clean
   always_comb begin
      nxt_ce_b   = (nxt_state == ST_IDLE) ? CTL_OFF : CTL_ON;
      nxt_oe_b   = (nxt_state == ST_RD) ? CTL_ON : CTL_OFF;
      nxt_we_b   = (nxt_state == ST_WR_PULSE) ? CTL_ON : CTL_OFF;
      nxt_dqoe_b = (nxt_state == ST_WR_SET || nxt_state == ST_WR_PULSE ||
                    nxt_state == ST_WR_HOLD) ? CTL_ON : CTL_OFF;
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         state_ff  <= ST_IDLE;
         cnt_ff    <= '0;
         sel_ff    <= '0;
         done_ff   <= '0;
         ce_b_ff   <= CTL_OFF;
         oe_b_ff   <= CTL_OFF;
         we_b_ff   <= CTL_OFF;
         dqoe_b_ff <= CTL_OFF;
         addr_ff   <= '0;
         dq_o_ff   <= '0;
         rda_ff    <= '0;
         rdb_ff    <= '0;
      end else begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         sel_ff    <= nxt_sel;
         done_ff   <= nxt_done;
         ce_b_ff   <= nxt_ce_b;
         oe_b_ff   <= nxt_oe_b;
         we_b_ff   <= nxt_we_b;
         dqoe_b_ff <= nxt_dqoe_b;
         addr_ff   <= nxt_addr;
         dq_o_ff   <= nxt_dq_o;
         rda_ff    <= nxt_rda;
         rdb_ff    <= nxt_rdb;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin data synchroniser; the two stages eat into the read window, so the
   // sram must answer within one cycle of the address for a four-cycle read
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         dq_s1_ff <= '0;
         dq_s2_ff <= '0;
      end else begin
         dq_s1_ff <= RAM_DQ_I;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   assign RD_DONE_A   = done_ff[CONS_RD_A];
   assign RD_DONE_B   = done_ff[CONS_RD_B];
   assign WR_DONE     = done_ff[CONS_WR];
   assign RD_DATA_A   = rda_ff;
   assign RD_DATA_B   = rdb_ff;
   assign RAM_CE_B    = ce_b_ff;
   assign RAM_OE_B    = oe_b_ff;
   assign RAM_WE_B    = we_b_ff;
   assign RAM_ADDR    = addr_ff;
   assign RAM_DQ_O    = dq_o_ff;
   assign RAM_DQ_OE_B = dqoe_b_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   property p_idle_ctl_off;
      state_ff == ST_IDLE |-> RAM_CE_B && RAM_OE_B && RAM_WE_B && RAM_DQ_OE_B;
   endproperty
   a_idle_ctl_off: assert property (p_idle_ctl_off) else $error("controls active in idle");

   property p_addr_stable;
      !RAM_CE_B && $past(!RAM_CE_B) |-> $stable(RAM_ADDR);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address moved while enabled");

   property p_data_stable;
      !RAM_DQ_OE_B && $past(!RAM_DQ_OE_B) |-> $stable(RAM_DQ_O) && !RAM_CE_B;
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("write data moved while driven");

   property p_idle_wait;
      state_ff == ST_IDLE && !ab.any |=> state_ff == ST_IDLE && RAM_CE_B;
   endproperty
   a_idle_wait: assert property (p_idle_wait) else $error("access started without request");

   property p_done_single;
      $onehot0(done_ff) && (done_ff == '0 || state_ff == ST_DONE && done_ff == sel_ff);
   endproperty
   a_done_single: assert property (p_done_single) else $error("completion to wrong consumer");

   property p_pending;
      state_ff != ST_IDLE |=> $stable(sel_ff);
   endproperty
   a_pending: assert property (p_pending) else $error("selection changed mid access");

   property p_priority;
      state_ff == ST_IDLE && RD_START_A |=> sel_ff == 3'h1 && state_ff == ST_RD;
   endproperty
   a_priority: assert property (p_priority) else $error("first consumer lost arbitration");

   property p_read_lat;
      state_ff == ST_IDLE && ab.gnt[CONS_RD_B] |-> !RD_DONE_B[*4] ##1 RD_DONE_B && RD_DATA_B == $past(dq_s2_ff);
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read not done in four cycles");

   property p_we_setup;
      $fell(RAM_WE_B) |-> $past(!RAM_CE_B) && $past(!RAM_DQ_OE_B) && $stable(RAM_ADDR);
   endproperty
   a_we_setup: assert property (p_we_setup) else $error("write strobe before settle");

   property p_we_width;
      $fell(RAM_WE_B) |-> !RAM_WE_B[*2] ##1 RAM_WE_B ##1 WR_DONE;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

   property p_release;
      done_ff != '0 |=> RAM_CE_B && RAM_OE_B && done_ff == '0 && state_ff == ST_IDLE;
   endproperty
   a_release: assert property (p_release) else $error("no release after completion");

   c_read_a:  cover property (state_ff == ST_IDLE && ab.gnt[CONS_RD_A] ##4 RD_DONE_A);
   c_read_b:  cover property (state_ff == ST_IDLE && ab.gnt[CONS_RD_B] ##4 RD_DONE_B);
   c_write:   cover property ($fell(RAM_WE_B) ##3 WR_DONE);
   c_all_req: cover property (state_ff == ST_IDLE && RD_START_A && RD_START_B && WR_START);

endmodule : lma_top

// ---- lma_sram_model.sv ----
// behavioural asynchronous sram standing on the far side of the arbiter
`timescale 1ns/100ps
module lma_sram_model
   import lma_pkg::*;
(
   input  wire logic              ce_b,
   input  wire logic              oe_b,
   input  wire logic              we_b,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] din,
   output      logic [DATA_W-1:0] dout
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   initial dout = '0;
   // the word lands at the end of the enable pulse, as the part does
   always @(posedge we_b) if (ce_b === 1'b0) mem[addr] = din;
   // a released pin flips so a stale word never passes for valid data
   always @(ce_b or oe_b or we_b or addr) begin
      if (ce_b === 1'b0 && oe_b === 1'b0 && we_b === 1'b1) dout = mem[addr];
      else dout = ~dout;
   end
endmodule : lma_sram_model

// ---- lut_memory_arbiter_test.sv ----
// self-checking bench of the look-up-table memory arbiter
`timescale 1ns/100ps
module lut_memory_arbiter_test;
   import lma_pkg::*;
   typedef struct {logic [DATA_W-1:0] d; int t;} lma_note_t;
   localparam int RL = READ_CYCLES + 1;
   localparam int WL = WE_CYCLES + 4;
   logic mclk = 1'b0, rst_b = 1'b0, rs_a = 1'b0, rs_b = 1'b0, ws = 1'b0;
   logic [ADDR_W-1:0] ra_a = '0, ra_b = '0, wa = '0, ram_addr, paddr;
   logic [DATA_W-1:0] wd = '0, rd_a, rd_b, dq_o, dq_i, sram_q, pdq;
   logic done_a, done_b, wdone, ce_b, oe_b, we_b, doe_b, pce = 1'b1, pdoe = 1'b1;
   logic [ADDR_W-1:0] a [8];
   logic [DATA_W-1:0] exp_mem [logic [ADDR_W-1:0]];
   lma_note_t qa [$], qb [$], qw [$];
   int err_count = 0, tests_run = 0, cyc = 0, wec = 0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   assign dq_i = (doe_b === 1'b0) ? dq_o : sram_q;
   lma_top u_dut (.MCLK(mclk), .RST_B(rst_b), .RD_START_A(rs_a), .RD_ADDR_A(ra_a), .RD_DATA_A(rd_a),
      .RD_DONE_A(done_a), .RD_START_B(rs_b), .RD_ADDR_B(ra_b), .RD_DATA_B(rd_b), .RD_DONE_B(done_b),
      .WR_START(ws), .WR_ADDR(wa), .WR_DATA(wd), .WR_DONE(wdone), .RAM_CE_B(ce_b), .RAM_OE_B(oe_b),
      .RAM_WE_B(we_b), .RAM_ADDR(ram_addr), .RAM_DQ_I(dq_i), .RAM_DQ_O(dq_o), .RAM_DQ_OE_B(doe_b));
   lma_sram_model u_sram (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .addr(ram_addr), .din(dq_o), .dout(sram_q));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic take(ref lma_note_t q [$], input logic [DATA_W-1:0] d);
      lma_note_t n;
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
         n = q.pop_front();
         chk(32'(d), 32'(n.d));
         chk(cyc, n.t);
      end
   endtask : take
   task automatic finish_test;
      $display("errors %0d comparisons %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   // hold the level until the pulse is seen, drop it one edge later
   task automatic wait_done(ref logic done, ref logic start);
      for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge mclk);
      chk(32'(done), 32'h1);
      @(posedge mclk);
      #1 start = 1'b0;
      @(posedge mclk);
      #1;
   endtask : wait_done
   task automatic rd(input int p, input logic [ADDR_W-1:0] ad, input int lat);
      lma_note_t n;
      n.d = exp_mem[ad];
      // lat counts whole slots, each closed by a release cycle the last slot does not wait for
      n.t = cyc + lat - 1;
      if (p == 0) begin
         qa.push_back(n);
         ra_a = ad;
         rs_a = 1'b1;
         wait_done(done_a, rs_a);
      end else begin
         qb.push_back(n);
         ra_b = ad;
         rs_b = 1'b1;
         wait_done(done_b, rs_b);
      end
   endtask : rd
   task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d, input int lat);
      lma_note_t n;
      n.d = '0;
      n.t = cyc + lat - 1;
      qw.push_back(n);
      exp_mem[ad] = d;
      wa = ad;
      wd = d;
      ws = 1'b1;
      wait_done(wdone, ws);
   endtask : wr
   task automatic idle_chk;
      repeat (3) begin
         @(negedge mclk);
         chk({ce_b, oe_b, we_b, doe_b, done_a, done_b, wdone}, 32'h78);
      end
      @(posedge mclk);
      #1;
   endtask : idle_chk
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge mclk) begin
      if (done_a === 1'b1) take(qa, rd_a);
      if (done_b === 1'b1) take(qb, rd_b);
      if (wdone === 1'b1) take(qw, '0);
      chk(32'(done_a + done_b + wdone > 2'h1), 32'h0);
      if (ce_b === 1'b0 && pce === 1'b0) chk(32'(ram_addr), 32'(paddr));
      if (doe_b === 1'b0 && pdoe === 1'b0) chk(32'(dq_o), 32'(pdq));
      if (we_b === 1'b0) begin
         if (wec == 0) chk(32'(pdoe), 32'h0);
         chk({ce_b, doe_b}, 32'h0);
         wec++;
      end else if (wec != 0) begin
         chk(32'(wec >= WE_CYCLES), 32'h1);
         wec = 0;
      end
      pce = ce_b;
      pdoe = doe_b;
      paddr = ram_addr;
      pdq = dq_o;
   end
   initial begin
      #(4 * 20000);
      err_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hF413B247));
      repeat (5) @(posedge mclk);
      #1 rst_b = 1'b1;
      idle_chk();
      for (int i = 0; i < 8; i++) a[i] = (i == 0) ? 15'h0000 : (i == 7) ? 15'h7FFF : {i[2:0], 12'($urandom)};
      for (int i = 0; i < 8; i++) wr(a[i], 8'($urandom), WL);
      for (int i = 0; i < 8; i++) begin
         rd(0, a[i], RL);
         rd(1, a[7 - i], RL);
      end
      // all three at once: served strictly in the fixed order
      fork
         rd(0, a[0], RL);
         rd(1, a[1], 2 * RL);
         wr(a[2], 8'($urandom), 2 * RL + WL);
      join
      fork
         rd(1, a[2], RL);
         wr(a[3], 8'($urandom), RL + WL);
      join
      rd(0, a[3], RL);
      // reset in mid-read: the access is dropped, no pulse may follow
      rs_a = 1'b1;
      ra_a = a[4];
      repeat (2) @(posedge mclk);
      #1 rst_b = 1'b0;
      rs_a = 1'b0;
      // the reset only takes hold at the next edge
      @(posedge mclk);
      idle_chk();
      rst_b = 1'b1;
      idle_chk();
      rd(0, a[4], RL);
      finish_test();
   end
endmodule : lut_memory_arbiter_test
